// [hdl/dmx_front.sv]
// Input multiplexer, mode select and timing check of the converter
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dmx_front (
    input wire logic clock,
    input wire logic srst,
    input wire logic [dmx_pkg::ADDR_W-1:0] addr,
    input wire logic [dmx_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [dmx_pkg::DATA_W-1:0] rdata,
    input wire logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] port_data_p,
    input wire logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] port_data_n,
    input wire logic input_check_pair_p,
    input wire logic input_check_pair_n,
    input wire logic sync_in_p,
    input wire logic sync_in_n,
    output logic source_clock_out_p,
    output logic source_clock_out_n,
    output logic setup_violation_flag,
    output logic hold_violation_flag,
    output logic [dmx_pkg::PORT_W-1:0] conv_word,
    output logic nonreturn_output,
    output logic narrow_return_output,
    output logic half_return_output,
    output logic rf_output,
    output logic irq
);

    localparam int PW = dmx_pkg::PORT_W;
    localparam int NP = dmx_pkg::NPORT;
    localparam int SW = 2 * NP * PW + 4;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    wire logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_q;
    logic [NP-1:0][PW-1:0] sd_p;
    logic [NP-1:0][PW-1:0] sd_n;
    logic chk_p;
    logic chk_n;
    logic syn_p;
    logic syn_n;

    // Complements enter inverted, so the flushed zero reads as an idle pair
    assign pins_raw = {port_data_p, ~port_data_n, input_check_pair_p,
                       ~input_check_pair_n, sync_in_p, ~sync_in_n};

    // Bits may skew by a cycle; the check pair flags exactly that
    dmx_sync #(.W(SW)) u_sync (
        .clock(clock),
        .srst(srst),
        .d(pins_raw),
        .q(pins_q)
    );

    assign {sd_p, sd_n, chk_p, chk_n, syn_p, syn_n} = pins_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration and sync alignment

    dmx_pkg::dmx_cfg_t cfg;
    dmx_pkg::dmx_evt_t status;
    dmx_pkg::dmx_evt_t mask;
    dmx_pkg::dmx_evt_t evt;
    dmx_pkg::dmx_evt_t next_status;
    logic syn_lvl_d;
    wire logic syn_lvl;
    wire logic align;

    assign syn_lvl = syn_p & syn_n;
    assign align = syn_lvl & ~syn_lvl_d; // R6

    always_ff @(posedge clock)
    begin
        if (srst)
            syn_lvl_d <= 1'b0;
        else
            syn_lvl_d <= syn_lvl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Word slot sequencing

    logic [1:0] slot;
    logic [1:0] next_slot;
    wire logic [1:0] slot_last;
    wire logic slot0;

    assign slot_last = (cfg.ratio == dmx_pkg::RATIO_TWO) ?
                       dmx_pkg::SLOT_LAST_TWO : dmx_pkg::SLOT_LAST_FOUR; // R1
    assign slot0 = (slot == dmx_pkg::SLOT_FIRST);
    // Wraps at two slots in two-port ratio, so C and D are never read
    assign next_slot = (align || slot >= slot_last) ? dmx_pkg::SLOT_FIRST :
                       2'(slot + 2'h1); // R2 R3

    always_ff @(posedge clock)
    begin
        if (srst)
            slot <= dmx_pkg::SLOT_FIRST;
        else
            slot <= next_slot;
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture and serialisation toward the converter

    logic [NP-1:0][PW-1:0] word_buf;
    wire logic [PW-1:0] next_word;

    // Port A goes straight through so the frame adds no extra latency
    assign next_word = slot0 ? sd_p[0] : word_buf[slot]; // R11 R9

    always_ff @(posedge clock)
    begin
        if (srst)
            word_buf <= '0;
        else if (slot0)
            word_buf <= sd_p;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            conv_word <= '0;
        else
            conv_word <= next_word; // R11
    end

    ////////////////////////////////////////////////////////////////////////
    // Differential integrity of the active ports

    wire logic [NP-1:0] pair_bad;
    wire logic [NP-1:0] act_mask;

    assign act_mask = dmx_pkg::port_mask(cfg.ratio); // R3

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pair
            assign pair_bad[gi] = act_mask[gi] & |(sd_p[gi] ^ sd_n[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timing check on the toggling check pair

    logic chk_prev;
    logic chk_cap;
    wire logic setup_hit;
    wire logic hold_hit;
    wire logic hold_slot;

    // A change just before capture means late data, just after means early
    assign hold_slot = (slot == dmx_pkg::SLOT_HOLD_CHECK);
    assign setup_hit = slot0 & (chk_prev != chk_p); // R7
    assign hold_hit = hold_slot & (chk_p != chk_cap); // R7

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            chk_prev <= 1'b0;
            chk_cap <= 1'b0;
        end
        else
        begin
            chk_prev <= chk_p;
            if (slot0)
                chk_cap <= chk_p;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            setup_violation_flag <= 1'b0;
            hold_violation_flag <= 1'b0;
        end
        else
        begin
            if (slot0)
                setup_violation_flag <= setup_hit; // R7
            if (hold_slot)
                hold_violation_flag <= hold_hit; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output mode decode

    logic [3:0] mode_q;

    always_ff @(posedge clock)
    begin
        if (srst)
            mode_q <= dmx_pkg::MODE_OH_RESET; // R5
        else
            mode_q <= dmx_pkg::mode_onehot(cfg.mode); // R4
    end

    assign nonreturn_output = mode_q[0];
    assign narrow_return_output = mode_q[1];
    assign half_return_output = mode_q[2];
    assign rf_output = mode_q[3];

    ////////////////////////////////////////////////////////////////////////
    // Output clock

    dmx_clkgen u_clkgen (
        .clock(clock),
        .srst(srst),
        .align(align),
        .ratio(cfg.ratio),
        .div(cfg.div),
        .phase(cfg.phase),
        .clk_p(source_clock_out_p),
        .clk_n(source_clock_out_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port

    wire logic wr_ctrl;
    wire logic wr_status;
    wire logic wr_mask;
    wire logic [dmx_pkg::EVT_W-1:0] clr_bits;
    wire logic [7:0] state_word;
    logic [dmx_pkg::DATA_W-1:0] rd_mux;

    assign wr_ctrl = wr && (addr == dmx_pkg::ADDR_CTRL);
    assign wr_status = wr && (addr == dmx_pkg::ADDR_STATUS);
    assign wr_mask = wr && (addr == dmx_pkg::ADDR_MASK);
    assign clr_bits = wr_status ? wdata[dmx_pkg::EVT_W-1:0] : '0;

    assign evt = {slot0 & ((|pair_bad) | (chk_p ^ chk_n)), align, hold_hit,
                  setup_hit};

    // A new event outranks a clear in the same cycle
    assign next_status = (status & ~clr_bits) | evt;

    assign state_word = {dmx_pkg::mode_onehot(cfg.mode), slot,
                         hold_violation_flag, setup_violation_flag};

    always_comb
    begin
        rd_mux = '0;
        unique case (addr)
            dmx_pkg::ADDR_CTRL: rd_mux[dmx_pkg::CFG_W-1:0] = cfg;
            dmx_pkg::ADDR_STATUS: rd_mux[dmx_pkg::EVT_W-1:0] = status;
            dmx_pkg::ADDR_MASK: rd_mux[dmx_pkg::EVT_W-1:0] = mask;
            dmx_pkg::ADDR_STATE: rd_mux[7:0] = state_word;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cfg <= dmx_pkg::CFG_RESET; // R5
            status <= dmx_pkg::EVT_NONE;
            mask <= dmx_pkg::EVT_NONE;
            rdata <= '0;
        end
        else
        begin
            if (wr_ctrl)
                cfg <= wdata[dmx_pkg::CFG_W-1:0];
            if (wr_mask)
                mask <= wdata[dmx_pkg::EVT_W-1:0];
            status <= next_status;
            rdata <= rd ? rd_mux : '0;
        end
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_FOUR_STEP: assert property ( // R1
        (cfg.ratio == dmx_pkg::RATIO_FOUR && slot == 2'h1 && !align)
        ##1 $stable(cfg.ratio) |-> slot == 2'h2)
        else $error("four-port slot did not advance to C");

    AST_FOUR_WRAP: assert property ( // R1
        (cfg.ratio == dmx_pkg::RATIO_FOUR && slot == 2'h3) |=> slot0)
        else $error("four-port frame did not wrap after D");

    AST_TWO_WRAP: assert property ( // R2
        (cfg.ratio == dmx_pkg::RATIO_TWO && slot == 2'h1) |=> slot0)
        else $error("two-port frame did not wrap after B");

    AST_IGNORE_CD: assert property ( // R3
        (cfg.ratio == dmx_pkg::RATIO_TWO && slot == 2'h1)
        |=> conv_word == $past(word_buf[1]) && !pair_bad[2] && !pair_bad[3])
        else $error("two-port mode used port C or D");

    AST_MODE_DECODE: assert property ( // R4
        $stable(cfg.mode) |=>
        mode_q == (4'h1 << $past(cfg.mode)) && $onehot(mode_q))
        else $error("output mode decode wrong");

    AST_RESET_RF: assert property ( // R5
        @(posedge clock) disable iff (1'b0)
        srst |=> rf_output && cfg.mode == dmx_pkg::MODE_RF)
        else $error("mode not RF after reset");

    AST_SYNC_ALIGN: assert property ( // R6
        $rose(syn_lvl) |=> slot0 && !source_clock_out_p)
        else $error("sync did not realign frame");

    AST_SETUP_FLAG: assert property ( // R7
        (slot0 && chk_prev != chk_p) |=> setup_violation_flag [*1]
        ##1 (slot0 || setup_violation_flag))
        else $error("setup violation not flagged");

    AST_HOLD_FLAG: assert property ( // R7
        (hold_slot && chk_p != chk_cap) |=> hold_violation_flag)
        else $error("hold violation not flagged");

    AST_CLK_DIFF: assert property ( // R8
        source_clock_out_p != source_clock_out_n)
        else $error("output clock pair not complementary");

    AST_ORDER_A: assert property ( // R11
        slot0 |=> conv_word == $past(sd_p[0]))
        else $error("first word of frame is not port A");

    AST_IRQ_STICKY: assert property (
        (evt.setup && wr_status && wdata[0]) |=> status.setup)
        else $error("clear beat a new setup event");

    COV_TWO_PORT: cover property (
        cfg.ratio == dmx_pkg::RATIO_TWO && slot == 2'h1 ##1 slot0);
    COV_SYNC: cover property ($rose(syn_lvl) ##1 slot0);
    COV_SETUP: cover property ($rose(setup_violation_flag));
    COV_IRQ: cover property ($rose(irq) ##[1:20] !irq);

endmodule

// [hdl/dmx_pkg.sv]
// Constants, carriers and decode helpers of the converter front end
//
// Overview of operation
// [R1] Ratio select low: all four ports A..D interleave, full conversion rate.
// [R2] Ratio select high: only two ports interleave; system keeps clock low.
// [R3] Two-port ratio ignores ports C and D; source may leave them open.
// [R4] Mode code 00 non-return, 01 narrow return, 10 half return, 11 RF.
// [R5] Mode select at its idle default is code 11, RF output.
// [R6] Active-high differential sync input realigns the internal word timing.
// [R7] Separate setup and hold violation flags report input check results.
// [R8] Differential output clock toward source, rate set by divide select.
// [R9] Source drives every port as 10-bit true/complement differential word.
// [R10] Three-bit phase select shifts output clock against master clock.
// [R11] Words leave in order A,B,C,D or A,B, one per clock.
package dmx_pkg;

    localparam int PORT_W = 10;
    localparam int NPORT = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 4'hc;

    localparam logic RATIO_FOUR = 1'b0;
    localparam logic RATIO_TWO = 1'b1;

    localparam logic [1:0] MODE_NONRET = 2'h0;
    localparam logic [1:0] MODE_NARROW = 2'h1;
    localparam logic [1:0] MODE_HALF = 2'h2;
    localparam logic [1:0] MODE_RF = 2'h3;
    localparam logic [3:0] MODE_OH_RESET = 4'h8;

    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;

    localparam logic [1:0] SLOT_FIRST = 2'h0;
    localparam logic [1:0] SLOT_HOLD_CHECK = 2'h1;
    localparam logic [1:0] SLOT_LAST_TWO = 2'h1;
    localparam logic [1:0] SLOT_LAST_FOUR = 2'h3;

    localparam logic [4:0] WORDS_FOUR = 5'h4;
    localparam logic [4:0] WORDS_TWO = 5'h2;
    localparam logic [3:0] MASK_FOUR = 4'hf;
    localparam logic [3:0] MASK_TWO = 4'h3;

    typedef struct packed {
        logic [2:0] phase;
        logic [1:0] div;
        logic [1:0] mode;
        logic ratio;
    } dmx_cfg_t;

    localparam int CFG_W = $bits(dmx_cfg_t);
    localparam dmx_cfg_t CFG_RESET = '{phase: 3'h0, div: DIV_1,
                                      mode: MODE_RF, ratio: RATIO_FOUR};

    typedef struct packed {
        logic pair_fault;
        logic sync_seen;
        logic hold;
        logic setup;
    } dmx_evt_t;

    localparam int EVT_W = $bits(dmx_evt_t);
    localparam dmx_evt_t EVT_NONE = '{default: 1'b0};

    // One-hot: bit0 non-return, bit1 narrow, bit2 half, bit3 RF
    function automatic logic [3:0] mode_onehot(input logic [1:0] m);
        return 4'h1 << m;
    endfunction

    function automatic logic [3:0] port_mask(input logic ratio);
        return (ratio == RATIO_TWO) ? MASK_TWO : MASK_FOUR;
    endfunction

    // Half period of the output clock: ports per frame times divide factor
    function automatic logic [4:0] half_period(input logic ratio,
                                               input logic [1:0] div);
        logic [4:0] n;
        n = (ratio == RATIO_TWO) ? WORDS_TWO : WORDS_FOUR;
        case (div)
            DIV_2: return n << 1;
            DIV_4: return n << 2;
            default: return n;
        endcase
    endfunction

endpackage

// [hdl/dmx_sync.sv]
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module dmx_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// [hdl/dmx_clkgen.sv]
// Divided, phase-shifted differential clock toward the data source
`timescale 1ns/1ps
module dmx_clkgen (
    input wire logic clock,
    input wire logic srst,
    input wire logic align,
    input wire logic ratio,
    input wire logic [1:0] div,
    input wire logic [2:0] phase,
    output logic clk_p,
    output logic clk_n
);

    logic [4:0] cnt;
    logic raw;
    logic [7:0] dly;
    wire logic [4:0] half;
    wire logic at_end;

    assign half = dmx_pkg::half_period(ratio, div); // R8
    assign at_end = (cnt >= 5'(half - 5'h1));

    always_ff @(posedge clock)
    begin
        if (srst || align || at_end)
            cnt <= 5'h0;
        else
            cnt <= 5'(cnt + 5'h1);
    end

    // Sync forces a known low phase so several devices line up
    always_ff @(posedge clock)
    begin
        if (srst || align)
            raw <= 1'b0;
        else if (at_end)
            raw <= ~raw; // R8
    end

    // Each tap is one master period; finer steps need the analog delay line
    always_ff @(posedge clock)
    begin
        if (srst || align)
        begin
            dly <= 8'h0;
            clk_p <= 1'b0;
            clk_n <= 1'b1;
        end
        else
        begin
            dly <= {dly[6:0], raw};
            clk_p <= dly[phase]; // R10
            clk_n <= ~dly[phase];
        end
    end

endmodule

// [sim/dmx_src.sv]
// Data source model driving the converter's differential input ports
`timescale 1ns/1ps
module dmx_src (
    input wire logic clock,
    input wire logic two_port,
    input wire logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] words,
    input wire logic chk_toggle,
    input wire logic bad_pair,
    input wire logic sync_req,
    output logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] port_data_p,
    output logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] port_data_n,
    output logic input_check_pair_p,
    output logic input_check_pair_n,
    output logic sync_in_p,
    output logic sync_in_n
);
    logic [dmx_pkg::PORT_W-1:0] wander = 10'h155;
    logic chk = 1'b0;

    always @(posedge clock)
    begin
        wander <= ~wander;
        if (chk_toggle)
            chk <= ~chk;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        port_data_p = words;
        port_data_n = ~words;
        // Broken pair only when a test asks for it
        if (bad_pair)
            port_data_n[0][0] = words[0][0];
        if (two_port)
        begin
            // Open ports float: changing, and both lines alike
            port_data_p[2] = wander;
            port_data_n[2] = wander;
            port_data_p[3] = ~wander;
            port_data_n[3] = ~wander;
        end
        input_check_pair_p = chk;
        input_check_pair_n = ~chk;
        sync_in_p = sync_req;
        sync_in_n = ~sync_req;
    end
endmodule

// [sim/tb_dmx_front.sv]
// Self-checking bench of the converter front end
`timescale 1ns/1ps
module tb_dmx_front;
    logic clock = 1'b0;
    logic srst, wr, rd, two_port, chk_toggle, bad_pair, sync_req;
    logic [dmx_pkg::ADDR_W-1:0] addr;
    logic [dmx_pkg::DATA_W-1:0] wdata, rdata, v;
    logic [dmx_pkg::NPORT-1:0][dmx_pkg::PORT_W-1:0] words, dp, dn;
    logic [dmx_pkg::PORT_W-1:0] conv_word;
    logic chk_p, chk_n, syn_p, syn_n, clk_p, clk_n, setup_f, hold_f, irq;
    logic m_nr, m_na, m_hf, m_rf;
    logic [7:0] cfgs [6] = '{8'h06, 8'h0e, 8'h16, 8'h1e, 8'h07, 8'ha6};
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n, i, d0;

    always #25 clock = ~clock;

    dmx_src i_dmx_src (.clock(clock), .two_port(two_port), .words(words),
        .chk_toggle(chk_toggle), .bad_pair(bad_pair), .sync_req(sync_req),
        .port_data_p(dp), .port_data_n(dn), .input_check_pair_p(chk_p),
        .input_check_pair_n(chk_n), .sync_in_p(syn_p), .sync_in_n(syn_n));

    dmx_front i_dmx_front (.clock(clock), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_data_p(dp),
        .port_data_n(dn), .input_check_pair_p(chk_p),
        .input_check_pair_n(chk_n), .sync_in_p(syn_p), .sync_in_n(syn_n),
        .source_clock_out_p(clk_p), .source_clock_out_n(clk_n),
        .setup_violation_flag(setup_f), .hold_violation_flag(hold_f),
        .conv_word(conv_word), .nonreturn_output(m_nr),
        .narrow_return_output(m_na), .half_return_output(m_hf),
        .rf_output(m_rf), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Find port A on the converter, then expect the rest in order
    task automatic frame(input int np);
        int k;
        #1;
        for (k = 0; k < 20 && conv_word !== words[0]; k++)
        begin
            @(posedge clock);
            #1;
        end
        check(32'(conv_word), 32'(words[0]), "frame start");
        for (k = 1; k < 2 * np; k++)
        begin
            @(posedge clock);
            #1;
            check(32'(conv_word), 32'(words[k % np]), "word order");
        end
    endtask

    // Raise sync, then count clocks until the output clock first rises
    task automatic sync_delay(output int d);
        sync_req <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(32'(conv_word), 32'(words[0]), "frame restart");
        check(clk_p, 1'b0, "clock low after sync");
        for (d = 4; d < 60 && clk_p !== 1'b1; d++)
        begin
            @(posedge clock);
            #1;
        end
        sync_req <= 1'b0;
    endtask

    task automatic period(output int p);
        int k, first;
        logic prev;
        first = -1;
        p = 0;
        prev = 1'b1;
        for (k = 0; k < 200 && p == 0; k++)
        begin
            @(posedge clock);
            #1;
            if (clk_p === 1'b1 && prev === 1'b0)
            begin
                if (first >= 0)
                    p = k - first;
                first = k;
            end
            prev = clk_p;
        end
    endtask

    always @(posedge clock)
    begin
        cycles++;
        // Whole run needs about 600 cycles
        if (cycles == 6000)
        begin
            errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        words = {10'h3c4, 10'h2b3, 10'h1a2, 10'h091};
        two_port = 1'b0;
        chk_toggle = 1'b0;
        bad_pair = 1'b0;
        sync_req = 1'b0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd_reg(dmx_pkg::ADDR_CTRL, v);
        check(v, 32'h6, "reset mode code");
        check({m_rf, m_hf, m_na, m_nr}, 4'h8, "reset RF output");
        wr_reg(4'h2, 32'hffff_ffff);
        rd_reg(4'h2, v);
        check(v, 32'h0, "unmapped read");
        rd_reg(dmx_pkg::ADDR_CTRL, v);
        check(v, 32'h6, "unmapped write ignored");
        $display("reset test done");
        for (i = 0; i < 4; i++)
        begin
            wr_reg(dmx_pkg::ADDR_CTRL, {29'h0, i[1:0], 1'b0});
            repeat (2) @(posedge clock);
            #1;
            check({m_rf, m_hf, m_na, m_nr}, 32'h1 << i, "mode");
        end
        wr_reg(dmx_pkg::ADDR_CTRL, 32'h6);
        repeat (4) @(posedge clock);
        frame(4);
        $display("mode and four-port test done");
        two_port <= 1'b1;
        wr_reg(dmx_pkg::ADDR_CTRL, 32'h7);
        repeat (6) @(posedge clock);
        wr_reg(dmx_pkg::ADDR_STATUS, 32'hf);
        frame(2);
        rd_reg(dmx_pkg::ADDR_STATUS, v);
        check(v[3], 1'b0, "open ports ignored");
        two_port <= 1'b0;
        wr_reg(dmx_pkg::ADDR_CTRL, 32'h6);
        $display("two-port test done");
        wr_reg(dmx_pkg::ADDR_MASK, 32'h8);
        wr_reg(dmx_pkg::ADDR_STATUS, 32'hf);
        check(irq, 1'b0, "irq idle");
        bad_pair <= 1'b1;
        repeat (10) @(posedge clock);
        bad_pair <= 1'b0;
        repeat (10) @(posedge clock);
        rd_reg(dmx_pkg::ADDR_STATUS, v);
        check(v[3], 1'b1, "pair fault");
        check(irq, 1'b1, "irq raised");
        wr_reg(dmx_pkg::ADDR_MASK, 32'h0);
        check(irq, 1'b0, "irq masked");
        wr_reg(dmx_pkg::ADDR_MASK, 32'h8);
        check(irq, 1'b1, "irq sticky");
        wr_reg(dmx_pkg::ADDR_STATUS, 32'h8);
        check(irq, 1'b0, "irq cleared");
        $display("interrupt test done");
        chk_toggle <= 1'b1;
        repeat (12) @(posedge clock);
        #1;
        check({setup_f, hold_f}, 2'h3, "violation flags set");
        rd_reg(dmx_pkg::ADDR_STATUS, v);
        check(v[1:0], 2'h3, "violation status");
        rd_reg(dmx_pkg::ADDR_STATE, v);
        check({v[7:4], v[1:0]}, 6'h23, "state word");
        // Clears at every slot offset, one meets a fresh setup event
        wr_reg(dmx_pkg::ADDR_STATUS, 32'h1);
        wr_reg(dmx_pkg::ADDR_STATUS, 32'h1);
        @(posedge clock);
        wr_reg(dmx_pkg::ADDR_STATUS, 32'h1);
        wr_reg(dmx_pkg::ADDR_STATUS, 32'h1);
        chk_toggle <= 1'b0;
        repeat (12) @(posedge clock);
        #1;
        check({setup_f, hold_f}, 2'h0, "violation flags clear");
        $display("timing check test done");
        wr_reg(dmx_pkg::ADDR_STATUS, 32'hf);
        sync_delay(d0);
        rd_reg(dmx_pkg::ADDR_STATUS, v);
        check(v[2], 1'b1, "sync seen");
        frame(4);
        $display("sync test done");
        for (i = 0; i < 6; i++)
        begin
            two_port <= cfgs[i][0];
            wr_reg(dmx_pkg::ADDR_CTRL, {24'h0, cfgs[i]});
            rd_reg(dmx_pkg::ADDR_CTRL, v);
            check(v, {24'h0, cfgs[i]}, "ctrl readback");
            repeat (40) @(posedge clock);
            period(n);
            check(n, 2 * (cfgs[i][0] ? 2 : 4) * (cfgs[i][4:3] == 2'h1 ? 2 :
                  cfgs[i][4:3] == 2'h2 ? 4 : 1), "clock period");
            check(clk_p ^ clk_n, 1'b1, "clock pair");
        end
        sync_delay(n);
        check(n - d0, 32'(cfgs[5][7:5]), "phase shift");
        $display("output clock test done");
        conclude();
    end
endmodule
